// ===== bench/dcwd_testbench.sv
`include "dcwd_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   core_clk_i;
    logic                   resetn_i;
    logic                   ce_i;
    logic [16:0]            nv_cfg_i;
    logic                   sel_osc_ready_i;
    logic                   pwm_wr_i;
    logic                   remap_done_i;
    logic                   hsel_i;
    logic [31:0]            haddr_i;
    logic [1:0]             htrans_i;
    logic                   hwrite_i;
    logic [2:0]             hsize_i;
    logic [31:0]            hwdata_i;
    logic [31:0]            hrdata_o;
    logic                   hreadyout_o;
    logic                   hresp_o;
    dcwd_pkg::dcwd_ctl_t    ctl_o;
    dcwd_pkg::dcwd_cfg_t    m_cfg;
    logic                   m_sw;
    logic                   m_unl;
    logic                   m_used;
    logic                   m_frc;
    int                     err_total;
    int                     n_tests;
    int                     cyc;
    logic [31:0]            rd;
    logic [16:0]            w;

    dcwd_top i_dcwd_top (
        .core_clk_i      (core_clk_i),
        .resetn_i        (resetn_i),
        .ce_i            (ce_i),
        .nv_cfg_i        (nv_cfg_i),
        .sel_osc_ready_i (sel_osc_ready_i),
        .pwm_wr_i        (pwm_wr_i),
        .remap_done_i    (remap_done_i),
        .hsel_i          (hsel_i),
        .haddr_i         (haddr_i),
        .htrans_i        (htrans_i),
        .hwrite_i        (hwrite_i),
        .hsize_i         (hsize_i),
        .hwdata_i        (hwdata_i),
        .hready_i        (hreadyout_o),
        .hrdata_o        (hrdata_o),
        .hreadyout_o     (hreadyout_o),
        .hresp_o         (hresp_o),
        .ctl_o           (ctl_o)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Ceiling well above the roughly 1200 cycles the sequence needs
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    function automatic dcwd_pkg::dcwd_ctl_t exp_ctl();
        dcwd_pkg::dcwd_ctl_t c;
        logic                xtal;
        xtal = m_cfg.primary_osc_mode inside {2'h1, 2'h2};
        c.cfg_valid        = 1'b1;
        c.code_protect     = !m_cfg.code_protect_n;
        c.write_protect    = !m_cfg.write_protect_n;
        c.osc_sel          = dcwd_pkg::dcwd_osc_t'(m_cfg.osc_source_sel);
        c.osc_reserved     = (m_cfg.osc_source_sel == 3'h4);
        c.active_src       = m_frc ? dcwd_pkg::OSC_FAST_RC : c.osc_sel;
        c.clk_switch_en    = !m_cfg.clk_switch_monitor_mode[1];
        c.fail_safe_en     = (m_cfg.clk_switch_monitor_mode == 2'h0);
        c.primary_mode     = dcwd_pkg::dcwd_posc_t'(m_cfg.primary_osc_mode);
        c.clkout_route     = m_cfg.clkout_pin_func & !xtal;
        c.osc_pin_two_gpio = !m_cfg.clkout_pin_func & !xtal;
        c.wdog_run         = m_cfg.wdog_hw_enable | m_sw;
        c.low_power_rc_keep_on     = m_cfg.wdog_hw_enable | m_sw;
        c.wdog_window_mode = !m_cfg.wdog_window_disable;
        c.pll_lock_en      = m_cfg.pll_lock_enable;
        c.tms_pullup_en    = m_cfg.test_port_enable;
        c.pwm_write_allow  = !m_cfg.pwm_key_lock_en | m_unl;
        c.remap_write_allow = !m_cfg.pin_remap_one_shot | !m_used;
        return c;
    endfunction

    // Long enough for a ready edge to pass the synchroniser and the state
    task automatic chk_ctl(input string m);
        repeat (6) @(posedge core_clk_i);
        chk(ctl_o === exp_ctl(), m);
    endtask

    // Single AHB-Lite word transfer, held until hready is seen high
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] r);
        @(posedge core_clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= a;
        hwrite_i <= wr;
        hsize_i  <= 3'h2;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
        chk(hresp_o === 1'b0, "response not okay");
    endtask

    task automatic pulse(input bit pwm);
        @(posedge core_clk_i);
        if (pwm) pwm_wr_i <= 1'b1;
        else remap_done_i <= 1'b1;
        @(posedge core_clk_i);
        pwm_wr_i     <= 1'b0;
        remap_done_i <= 1'b0;
    endtask

    task automatic do_reset(input logic [16:0] cw);
        int k;
        resetn_i <= 1'b0;
        nv_cfg_i <= cw;
        m_cfg = cw;
        m_sw = 1'b0;
        m_unl = 1'b0;
        m_used = 1'b0;
        m_frc = 1'b0;
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (k = 0; k < 20 && ctl_o.cfg_valid !== 1'b1; k++)
            @(posedge core_clk_i);
        repeat (8) @(posedge core_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        n_tests = 0;
        resetn_i = 1'b0;
        ce_i = 1'b1;
        nv_cfg_i = 17'h1FFFF;
        sel_osc_ready_i = 1'b1;
        pwm_wr_i = 1'b0;
        remap_done_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        void'($urandom(32'hAA94));
        // Erased word first, then every source, switch and primary code
        do_reset(17'h1FFFF);
        chk_ctl("erased decode");
        for (int i = 0; i < 16; i++) begin
            w = 17'($urandom);
            w[6:4] = i[2:0];
            w[8:7] = i[3:2];
            w[12:11] = i[1:0];
            do_reset(w);
            chk_ctl("field decode");
            chk_ctl("wdog decode");
            xfer(1'b0, 32'(`DCWD_OFF_CFG), 32'h0, rd);
            chk(rd === {15'h0, w}, "cfg readback");
            nv_cfg_i <= ~w;
            xfer(1'b1, 32'(`DCWD_OFF_CFG), 32'hFFFFFFFF, rd);
            xfer(1'b0, 32'(`DCWD_OFF_CFG), 32'h0, rd);
            chk(rd === {15'h0, w}, "cfg changed");
            chk_ctl("store change leaked");
        end
        $display("test decode done");
        // Two-speed start with the selected source held not ready
        for (int t = 0; t < 2; t++) begin
            w = 17'($urandom);
            w[2] = t[0];
            sel_osc_ready_i <= 1'b0;
            do_reset(w);
            m_frc = t[0];
            chk_ctl("start source");
            xfer(1'b0, 32'(`DCWD_OFF_STATUS), 32'h0, rd);
            chk(rd[`DCWD_ST_ON_FRC] === t[0], "start flag");
            sel_osc_ready_i <= 1'b1;
            m_frc = 1'b0;
            chk_ctl("switch after ready");
        end
        $display("test two-speed done");
        // Software watchdog bit under both hardware settings
        for (int h = 0; h < 2; h++) begin
            w = 17'($urandom);
            w[13] = h[0];
            do_reset(w);
            chk_ctl("wdog idle");
            xfer(1'b1, 32'(`DCWD_OFF_WDOG), 32'h1, rd);
            m_sw = 1'b1;
            chk_ctl("wdog sw on");
            xfer(1'b1, 32'(`DCWD_OFF_WDOG), 32'h0, rd);
            m_sw = 1'b0;
            chk_ctl("wdog sw off");
        end
        $display("test watchdog done");
        // Key sequence, consumption by a write, and a broken sequence
        for (int p = 0; p < 2; p++) begin
            w = 17'($urandom);
            w[3] = p[0];
            do_reset(w);
            chk_ctl("pwm locked");
            xfer(1'b1, 32'(`DCWD_OFF_PWM_KEY), `DCWD_PWM_KEY_A, rd);
            xfer(1'b1, 32'(`DCWD_OFF_PWM_KEY), `DCWD_PWM_KEY_B, rd);
            m_unl = 1'b1;
            chk_ctl("pwm unlocked");
            pulse(1'b1);
            m_unl = 1'b0;
            chk_ctl("pwm relocked");
            xfer(1'b1, 32'(`DCWD_OFF_PWM_KEY), `DCWD_PWM_KEY_A, rd);
            xfer(1'b1, 32'(`DCWD_OFF_PWM_KEY), 32'h00001234, rd);
            xfer(1'b1, 32'(`DCWD_OFF_PWM_KEY), `DCWD_PWM_KEY_B, rd);
            chk_ctl("broken key");
            xfer(1'b0, 32'(`DCWD_OFF_PWM_KEY), 32'h0, rd);
            chk(rd === 32'h0, "key reg readable");
            xfer(1'b0, 32'h00000010, 32'h0, rd);
            chk(rd === 32'h0, "unmapped read");
        end
        $display("test pwm key done");
        // Pin remap one-shot against repeated use
        for (int o = 0; o < 2; o++) begin
            w = 17'($urandom);
            w[9] = o[0];
            do_reset(w);
            chk_ctl("remap fresh");
            pulse(1'b0);
            m_used = 1'b1;
            chk_ctl("remap used");
            pulse(1'b0);
            chk_ctl("remap again");
        end
        $display("test remap done");
        // Clock enable low must freeze all state, the remap flag included
        do_reset(w);
        ce_i <= 1'b0;
        pulse(1'b0);
        chk_ctl("frozen remap");
        ce_i <= 1'b1;
        chk_ctl("thawed remap");
        $display("test clock enable done");
        summarize();
    end
endmodule

// ===== logic/dcwd_consts.svh
`ifndef DCWD_CONSTS_SVH
`define DCWD_CONSTS_SVH

// Register byte offsets
`define DCWD_OFF_CFG      8'h00
`define DCWD_OFF_STATUS   8'h04
`define DCWD_OFF_WDOG     8'h08
`define DCWD_OFF_PWM_KEY  8'h0C

// Configuration word width and erased (all ones) reset value
`define DCWD_CFG_W        17
`define DCWD_CFG_ERASED   17'h1FFFF

// Status register field positions
`define DCWD_ST_LOADED    0
`define DCWD_ST_UNLOCKED  1
`define DCWD_ST_REMAP     2
`define DCWD_ST_ON_FRC    3
`define DCWD_ST_KEYSTAGE  4

// Software watchdog enable position and reset value
`define DCWD_WDOG_SW_BIT  0
`define DCWD_WDOG_SW_RST  1'h0

// PWM unlock key pair, written in this order
`define DCWD_PWM_KEY_A    32'h0000ABCD
`define DCWD_PWM_KEY_B    32'h00004321

// Cycles after reset release before the stored word may be taken
`define DCWD_LOAD_SETTLE  2'h3

`endif

// ===== logic/dcwd_pkg.sv
package dcwd_pkg;

    typedef struct packed {
        logic       test_port_enable;
        logic       pll_lock_enable;
        logic       wdog_window_disable;
        logic       wdog_hw_enable;
        logic [1:0] primary_osc_mode;
        logic       clkout_pin_func;
        logic       pin_remap_one_shot;
        logic [1:0] clk_switch_monitor_mode;
        logic [2:0] osc_source_sel;
        logic       pwm_key_lock_en;
        logic       two_speed_startup_en;
        logic       write_protect_n;
        logic       code_protect_n;
    } dcwd_cfg_t;

    typedef enum logic [2:0] {
        OSC_FAST_RC,
        OSC_FAST_RC_DIV_N_PLL,
        OSC_PRIMARY,
        OSC_PRIMARY_PLL,
        OSC_RESERVED,
        OSC_LOW_POWER_RC,
        OSC_FAST_RC_DIV_16,
        OSC_FAST_RC_DIV_N
    } dcwd_osc_t;

    typedef enum logic [1:0] {
        POSC_EXTERNAL_CLOCK_IN,
        POSC_CRYSTAL_LOW_RANGE,
        POSC_CRYSTAL_HIGH_SPEED,
        POSC_DISABLED
    } dcwd_posc_t;

    typedef enum logic [1:0] {
        ST_LOAD,
        ST_FAST_RC_START,
        ST_RUN
    } dcwd_state_t;

    typedef struct packed {
        logic       cfg_valid;
        logic       code_protect;
        logic       write_protect;
        dcwd_osc_t  osc_sel;
        logic       osc_reserved;
        dcwd_osc_t  active_src;
        logic       clk_switch_en;
        logic       fail_safe_en;
        dcwd_posc_t primary_mode;
        logic       clkout_route;
        logic       osc_pin_two_gpio;
        logic       wdog_run;
        logic       low_power_rc_keep_on;
        logic       wdog_window_mode;
        logic       pll_lock_en;
        logic       tms_pullup_en;
        logic       pwm_write_allow;
        logic       remap_write_allow;
    } dcwd_ctl_t;

endpackage

// ===== logic/dcwd_top.sv
// Summary of operation
// - Code-protect field 0 protects all program memory
// - Write-protect field 0 blocks program memory writes
// - Two-speed start on fast RC, then switch
// - PWM lock needs key sequence before writes
// - Decode three-bit oscillator source select field
// - Decode clock switching and fail-safe monitor mode
// - One-shot field allows single pin remap
// - Clock-out on pin two unless crystal mode
// - Decode two-bit primary oscillator mode field
// - Hardware watchdog enable forces watchdog always on
// - Otherwise software bit runs watchdog, RC clock
// - Window-disable 0 selects watchdog window mode
// - PLL lock enable follows its field
// - Erased test-port field 1 enables TMS pull-up
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`include "dcwd_consts.svh"

module dcwd_top (
    input  wire logic                      core_clk_i,      // Core clock
    input  wire logic                      resetn_i,        // Async reset
    input  wire logic                      ce_i,            // Clock enable
    input  wire logic [`DCWD_CFG_W-1:0]    nv_cfg_i,        // Stored word
    input  wire logic                      sel_osc_ready_i, // Source ready
    input  wire logic                      pwm_wr_i,        // PWM reg write
    input  wire logic                      remap_done_i,    // Remap made
    input  wire logic                      hsel_i,          // AHB select
    input  wire logic [31:0]               haddr_i,         // AHB address
    input  wire logic [1:0]                htrans_i,        // AHB transfer
    input  wire logic                      hwrite_i,        // AHB write
    input  wire logic [2:0]                hsize_i,         // AHB size
    input  wire logic [31:0]               hwdata_i,        // AHB wdata
    input  wire logic                      hready_i,        // AHB ready
    output logic      [31:0]               hrdata_o,        // AHB rdata
    output logic                           hreadyout_o,     // AHB ready out
    output logic                           hresp_o,         // AHB response
    output dcwd_pkg::dcwd_ctl_t            ctl_o            // Decoded ctl
);

    ////////////////////////////////////////////////////////////////////////
    // Stored configuration capture

    logic [`DCWD_CFG_W-1:0] nv_s1;
    logic [`DCWD_CFG_W-1:0] nv_s2;
    logic [`DCWD_CFG_W-1:0] nv_s3;
    logic [1:0]             settle_cnt;
    logic                   loaded_q;
    dcwd_pkg::dcwd_cfg_t    cfg_q;
    logic                   rdy_s1;
    logic                   rdy_s2;
    logic                   rdy_s3;

    // Stored word and source ready come from outside this clock domain
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nv_s1 <= `DCWD_CFG_ERASED;
            nv_s2 <= `DCWD_CFG_ERASED;
            nv_s3 <= `DCWD_CFG_ERASED;
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            rdy_s3 <= 1'b0;
        end else if (ce_i) begin
            nv_s1 <= nv_cfg_i;
            nv_s2 <= nv_s1;
            nv_s3 <= nv_s2;
            rdy_s1 <= sel_osc_ready_i;
            rdy_s2 <= rdy_s1;
            rdy_s3 <= rdy_s2;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle_cnt <= 2'h0;
        end else if (ce_i && settle_cnt != `DCWD_LOAD_SETTLE) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    // Taken once after release; later changes of the store are ignored
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q    <= dcwd_pkg::dcwd_cfg_t'(`DCWD_CFG_ERASED);
            loaded_q <= 1'b0;
        end else if (ce_i && !loaded_q && settle_cnt == `DCWD_LOAD_SETTLE
                     && nv_s2 == nv_s3) begin
            cfg_q    <= dcwd_pkg::dcwd_cfg_t'(nv_s3);
            loaded_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up clock sequencing

    dcwd_pkg::dcwd_state_t state_q;
    logic                  rdy_ok;

    // Ready counts only once the last two stages are both high
    assign rdy_ok = rdy_s2 && rdy_s3;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= dcwd_pkg::ST_LOAD;
        end else if (ce_i) begin
            unique case (state_q)
                dcwd_pkg::ST_LOAD: begin
                    if (loaded_q && cfg_q.two_speed_startup_en) begin
                        state_q <= dcwd_pkg::ST_FAST_RC_START;
                    end else if (loaded_q) begin
                        state_q <= dcwd_pkg::ST_RUN;
                    end
                end
                dcwd_pkg::ST_FAST_RC_START: begin
                    if (rdy_ok) begin
                        state_q <= dcwd_pkg::ST_RUN;
                    end
                end
                dcwd_pkg::ST_RUN: state_q <= dcwd_pkg::ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    logic        addr_ok;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        wdog_sw_q;
    logic        key_stage_q;
    logic        pwm_unlocked_q;
    logic        remap_used_q;
    logic        key_wr;
    logic        key_done;
    logic [31:0] next_rdata;

    assign addr_ok = hsel_i && htrans_i[1] && hready_i;
    assign key_wr  = wr_pend_q && wr_addr_q == `DCWD_OFF_PWM_KEY;
    assign key_done = key_wr && key_stage_q && hwdata_i == `DCWD_PWM_KEY_B;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (ce_i) begin
            wr_pend_q <= addr_ok && hwrite_i;
            wr_addr_q <= haddr_i[7:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdog_sw_q <= `DCWD_WDOG_SW_RST;
        end else if (ce_i && wr_pend_q && wr_addr_q == `DCWD_OFF_WDOG) begin
            wdog_sw_q <= hwdata_i[`DCWD_WDOG_SW_BIT];
        end
    end

    // Key A then key B as consecutive writes; any other write restarts the sequence
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_stage_q <= 1'b0;
        end else if (ce_i && key_wr) begin
            key_stage_q <= hwdata_i == `DCWD_PWM_KEY_A;
        end else if (ce_i && wr_pend_q) begin
            key_stage_q <= 1'b0;
        end
    end

    // One unlock buys one PWM write; a fresh key beats the consume
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwm_unlocked_q <= 1'b0;
        end else if (ce_i) begin
            if (key_done) begin
                pwm_unlocked_q <= 1'b1;
            end else if (pwm_wr_i) begin
                pwm_unlocked_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remap_used_q <= 1'b0;
        end else if (ce_i && loaded_q && remap_done_i) begin
            remap_used_q <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr_i[7:0])
            `DCWD_OFF_CFG: begin
                next_rdata[`DCWD_CFG_W-1:0] = cfg_q;
            end
            `DCWD_OFF_STATUS: begin
                next_rdata[`DCWD_ST_LOADED]   = loaded_q;
                next_rdata[`DCWD_ST_UNLOCKED] = pwm_unlocked_q;
                next_rdata[`DCWD_ST_REMAP]    = remap_used_q;
                next_rdata[`DCWD_ST_ON_FRC]   = state_q != dcwd_pkg::ST_RUN;
                next_rdata[`DCWD_ST_KEYSTAGE] = key_stage_q;
            end
            `DCWD_OFF_WDOG: begin
                next_rdata[`DCWD_WDOG_SW_BIT] = wdog_sw_q;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            hrdata_o <= (addr_ok && !hwrite_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // Zero wait states and an OKAY answer to every access
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode

    dcwd_pkg::dcwd_ctl_t next_ctl;
    logic                crystal;

    assign crystal =
        cfg_q.primary_osc_mode == 2'(dcwd_pkg::POSC_CRYSTAL_LOW_RANGE)
        || cfg_q.primary_osc_mode == 2'(dcwd_pkg::POSC_CRYSTAL_HIGH_SPEED);

    always_comb begin
        next_ctl               = '0;
        next_ctl.cfg_valid     = loaded_q;
        next_ctl.code_protect  = !cfg_q.code_protect_n;
        next_ctl.write_protect = !cfg_q.write_protect_n;
        next_ctl.osc_sel       =
            dcwd_pkg::dcwd_osc_t'(cfg_q.osc_source_sel);
        next_ctl.osc_reserved  =
            cfg_q.osc_source_sel == 3'(dcwd_pkg::OSC_RESERVED);
        next_ctl.active_src    = (state_q == dcwd_pkg::ST_RUN)
                               ? next_ctl.osc_sel
                               : dcwd_pkg::OSC_FAST_RC;
        next_ctl.clk_switch_en = !cfg_q.clk_switch_monitor_mode[1];
        next_ctl.fail_safe_en  = cfg_q.clk_switch_monitor_mode == 2'h0;
        next_ctl.primary_mode  =
            dcwd_pkg::dcwd_posc_t'(cfg_q.primary_osc_mode);
        next_ctl.clkout_route  = cfg_q.clkout_pin_func && !crystal;
        next_ctl.osc_pin_two_gpio = !cfg_q.clkout_pin_func
                                 && !crystal;
        next_ctl.wdog_run      = cfg_q.wdog_hw_enable
                              || wdog_sw_q;
        next_ctl.low_power_rc_keep_on  = cfg_q.wdog_hw_enable
                              || wdog_sw_q;
        next_ctl.wdog_window_mode = !cfg_q.wdog_window_disable;
        next_ctl.pll_lock_en   = cfg_q.pll_lock_enable;
        next_ctl.tms_pullup_en = cfg_q.test_port_enable;
        next_ctl.pwm_write_allow = !cfg_q.pwm_key_lock_en
                                || pwm_unlocked_q;
        next_ctl.remap_write_allow = !cfg_q.pin_remap_one_shot
                                  || !remap_used_q;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_o <= '0;
        end else if (ce_i) begin
            ctl_o <= next_ctl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_code_prot;
        $past(ce_i) && $past(loaded_q) |->
            ctl_o.code_protect == !cfg_q.code_protect_n;
    endproperty
    a_code_prot: assert property (p_code_prot)
        else $error("code protect mismatch");

    property p_write_prot;
        $past(ce_i) && $past(loaded_q) |->
            ctl_o.write_protect == !cfg_q.write_protect_n;
    endproperty
    a_write_prot: assert property (p_write_prot)
        else $error("write protect mismatch");

    property p_two_speed;
        ce_i && state_q == dcwd_pkg::ST_FAST_RC_START && !rdy_ok
            |=> state_q == dcwd_pkg::ST_FAST_RC_START
                && (!$past(ce_i) || ctl_o.active_src == dcwd_pkg::OSC_FAST_RC);
    endproperty
    a_two_speed: assert property (p_two_speed)
        else $error("two-speed start left fast RC early");

    property p_pwm_key;
        ce_i && key_done ##1 ce_i |=> ctl_o.pwm_write_allow;
    endproperty
    a_pwm_key: assert property (p_pwm_key)
        else $error("key sequence did not unlock PWM");

    property p_osc_res;
        $past(ce_i) && $past(loaded_q) |->
            ctl_o.osc_reserved == (cfg_q.osc_source_sel == 3'h4);
    endproperty
    a_osc_res: assert property (p_osc_res)
        else $error("reserved oscillator code flag wrong");

    property p_fail_safe;
        $past(ce_i) && $past(loaded_q) |->
            !(ctl_o.fail_safe_en && !ctl_o.clk_switch_en);
    endproperty
    a_fail_safe: assert property (p_fail_safe)
        else $error("fail-safe on without clock switching");

    property p_remap;
        $past(ce_i) && $past(remap_used_q) && cfg_q.pin_remap_one_shot
            |-> !ctl_o.remap_write_allow;
    endproperty
    a_remap: assert property (p_remap)
        else $error("second pin remap allowed");

    property p_clkout;
        $past(ce_i) && $past(loaded_q) && crystal |-> !ctl_o.clkout_route;
    endproperty
    a_clkout: assert property (p_clkout)
        else $error("clock out routed in crystal mode");

    property p_wdog_hw;
        $past(ce_i) && $past(loaded_q) && cfg_q.wdog_hw_enable
            |-> ctl_o.wdog_run && ctl_o.low_power_rc_keep_on;
    endproperty
    a_wdog_hw: assert property (p_wdog_hw)
        else $error("watchdog stopped while forced on");

    property p_wdog_sw;
        $past(ce_i) && !cfg_q.wdog_hw_enable && $stable(cfg_q)
            |-> ctl_o.wdog_run == $past(wdog_sw_q);
    endproperty
    a_wdog_sw: assert property (p_wdog_sw)
        else $error("watchdog not following software bit");

    property p_window;
        $past(ce_i) && $past(loaded_q) |->
            ctl_o.wdog_window_mode != cfg_q.wdog_window_disable;
    endproperty
    a_window: assert property (p_window)
        else $error("watchdog window mode wrong");

    property p_hold;
        loaded_q |=> $stable(cfg_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("configuration changed after load");

endmodule
